/* File: rtl/spu_defs.svh */
// Purpose: constants of the four-mode serial port: addresses, fields, resets, divisors
// Assumes: 100 MHz core clock, byte-wide special-function register access
// Notes:   definitions only
`ifndef SPU_DEFS_SVH
`define SPU_DEFS_SVH

// register addresses and reset values
`define SPU_ADDR_CTRL        8'h98
`define SPU_ADDR_DATA        8'h99
`define SPU_CTRL_RESET       8'h00
`define SPU_DATA_RESET       8'h00

// control register field positions
`define SPU_BIT_MODE_HI      7
`define SPU_BIT_MODE_LO      6
`define SPU_BIT_MULTIPROC    5
`define SPU_BIT_RX_ENABLE    4
`define SPU_BIT_TX_NINTH     3
`define SPU_BIT_RX_NINTH     2
`define SPU_BIT_TX_DONE      1
`define SPU_BIT_RX_DONE      0

// core clock
`define SPU_CLK_PERIOD_NS    10

// shift-register mode: one bit per 12 core clocks, clock low for the first half
`define SPU_M0_DIV           12
`define SPU_M0_HALF          (`SPU_M0_DIV / 2)

// uart oversampling: 16 ticks per bit, mid-bit at tick 8
`define SPU_OS_RATE          16
`define SPU_OS_MID           (`SPU_OS_RATE / 2)

// fixed-baud mode: bit = clk/64 or clk/32, tick = bit * 16
`define SPU_M2_BIT_DIV0      64
`define SPU_M2_BIT_DIV1      32
`define SPU_M2_TICK_DIV0     (`SPU_M2_BIT_DIV0 / `SPU_OS_RATE)
`define SPU_M2_TICK_DIV1     (`SPU_M2_BIT_DIV1 / `SPU_OS_RATE)

// first timer: bit = ovf * 2^double / 32, so ticks need ovf / 2 without doubling
`define SPU_T1_BIT_DIV       32

// frame lengths in bits, start included
`define SPU_FRAME8_BITS      10
`define SPU_FRAME9_BITS      11

// transmit buffer depth
`define SPU_TXBUF_DEPTH      2

`endif

/* File: rtl/spu_pkg.sv */
// Purpose: types of the four-mode serial port
// Assumes: constants come from spu_defs.svh
// Notes:   state encodings are one-hot
`default_nettype none
package spu_pkg;

  typedef logic [7:0] spu_byte_t;

  // serial mode, encoding as held in the control register
  typedef enum logic [1:0] {
    SPU_MODE_SHIFT  = 2'b00,
    SPU_MODE_UART8  = 2'b01,
    SPU_MODE_UART9F = 2'b10,
    SPU_MODE_UART9V = 2'b11
  } spu_mode_t;

  typedef enum logic [2:0] {
    SPU_TX_IDLE  = 3'b001,
    SPU_TX_WAIT  = 3'b010,
    SPU_TX_SHIFT = 3'b100
  } spu_tx_st_t;

  typedef enum logic [2:0] {
    SPU_RX_IDLE  = 3'b001,
    SPU_RX_START = 3'b010,
    SPU_RX_DATA  = 3'b100
  } spu_rx_st_t;

  typedef enum logic [2:0] {
    SPU_M0_IDLE = 3'b001,
    SPU_M0_TX   = 3'b010,
    SPU_M0_RX   = 3'b100
  } spu_m0_st_t;

  // one queued transmit word: ninth bit plus data
  typedef struct packed {
    logic      ninth;
    spu_byte_t data;
  } spu_tx_entry_t;

  // whole state of the serial port core
  typedef struct packed {
    spu_byte_t  ctrl;
    spu_byte_t  rx_data;
    spu_byte_t  rdata;
    logic       txd;
    logic       rxd_o;
    logic       rxd_oe;
    logic       irq;
    logic       rxd_prev;
    logic [1:0] m2_div;
    logic       t1_pre;
    spu_tx_st_t tx_st;
    logic [3:0] tx_os;
    logic [3:0] tx_bits;
    logic [10:0] tx_sh;
    spu_rx_st_t rx_st;
    logic [3:0] rx_os;
    logic [3:0] rx_bits;
    logic [8:0] rx_sh;
    spu_m0_st_t m0_st;
    logic [3:0] m0_cnt;
    logic [2:0] m0_bit;
    spu_byte_t  m0_sh;
  } spu_state_t;

endpackage : spu_pkg
`default_nettype wire

/* File: rtl/spu_buf2.sv */
// Purpose: small transmit buffer with valid and ready on both sides
// Assumes: reset already synchronised by the caller
// Notes:   a push into a full buffer is refused, never overwrites
`timescale 1ns/100ps
`default_nettype none
module spu_buf2 #(
  parameter int W     = 9,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  // filling side
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  // draining side
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  import spu_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr_ptr;
    logic [AW-1:0]           rd_ptr;
    logic [CW-1:0]           count;
    logic                    not_full;
  } spu_buf_st_t;

  localparam spu_buf_st_t BUF_RESET = '{mem: '0, wr_ptr: '0, rd_ptr: '0, count: '0, not_full: 1'b1};

  spu_buf_st_t q;
  spu_buf_st_t d;
  logic        push;
  logic        pop;

  // handshakes on both sides
  assign push = i_in_valid & q.not_full;
  assign pop  = (q.count != '0) & i_out_ready;

  // pointer and count update
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wr_ptr] = i_in_data;
      d.wr_ptr = (q.wr_ptr == AW'(DEPTH - 1)) ? '0 : q.wr_ptr + 1'b1;
    end
    if (pop) begin
      d.rd_ptr = (q.rd_ptr == AW'(DEPTH - 1)) ? '0 : q.rd_ptr + 1'b1;
    end
    case ({push, pop})
      2'b10:   d.count = q.count + 1'b1;
      2'b01:   d.count = q.count - 1'b1;
      default: d.count = q.count;
    endcase
    d.not_full = (d.count != CW'(DEPTH));
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= BUF_RESET;
    end else begin
      q <= d;
    end
  end

  assign o_in_ready  = q.not_full;
  assign o_out_valid = (q.count != '0);
  assign o_out_data  = q.mem[q.rd_ptr];

endmodule : spu_buf2
`default_nettype wire

/* File: rtl/spu_uart.sv */
// Purpose: four-mode serial port with control and data registers
// Assumes: register strobes and timer overflow pulses synchronous to I_CLK_SYS
// Notes:   writes to the data register queue in a two-entry buffer
//
// Behaviour
// - data register write starts transmission; reads return separate receive register
// - control bits 7 and 6 select one of four modes
// - 8-bit uart with multiprocessor bit: receive flag only on valid stop
// - 9-bit modes with multiprocessor bit: no receive flag when ninth bit 0
// - reception only while receive enable bit 4 is set; shift mode finishes a started word after the bit clears
// - transmit ninth bit field is sent as ninth bit in 9-bit modes
// - received ninth bit field holds ninth bit, or stop bit in 8-bit mode
// - transmit done set after eighth bit or at stop start; software clears
// - receive done set after eighth bit or mid stop bit; software clears
// - shift mode: eight bits lsb first on data pin, transmit pin clocks
// - shift mode reception starts with enable set and receive done clear
// - 8-bit uart frame: start 0, eight data lsb first, stop 1
// - 8-bit uart write puts 1 in ninth shift position as stop bit
// - uart reception starts on falling receive pin, start bit validated and skipped
// - at final shift accept only if flag clear and filter passes, else drop
// - 9-bit uart frame: start, eight data, ninth bit, stop
// - fixed 9-bit mode runs at clock/64, or clock/32 when doubled
// - 9-bit transmission starts when the free-running 16-tick count next wraps after the write
// - variable 9-bit mode equals fixed mode with timer baud
// - variable modes take first or second timer per direction
// - shift mode runs at core clock divided by 12
// - timer select bits route second timer overflow to receiver or transmitter
// - first timer bit rate is overflow times 2^double over 32
// - second timer bit rate is overflow over 16
`timescale 1ns/100ps
`default_nettype none
`include "spu_defs.svh"
module spu_uart (
  // clock and reset
  input  wire logic              I_CLK_SYS,
  input  wire logic              I_RST_N,
  // register access
  input  wire spu_pkg::spu_byte_t I_SFR_ADDR,
  input  wire spu_pkg::spu_byte_t I_SFR_WDATA,
  input  wire logic              I_SFR_WR,
  input  wire logic              I_SFR_RD,
  output spu_pkg::spu_byte_t     O_SFR_RDATA,
  output logic                   O_TX_READY,
  // baud sources
  input  wire logic              I_BAUD_DOUBLE,
  input  wire logic              I_RX_TIMER_SELECT,
  input  wire logic              I_TX_TIMER_SELECT,
  input  wire logic              I_TIMER1_OVF,
  input  wire logic              I_TIMER2_OVF,
  // serial pins
  input  wire logic              I_RXD,
  output logic                   O_RXD,
  output logic                   O_RXD_OE,
  output logic                   O_TXD,
  // interrupt request
  output logic                   O_SERIAL_IRQ
);
  import spu_pkg::*;

  localparam spu_state_t ST_RESET = '{
    ctrl: `SPU_CTRL_RESET, rx_data: `SPU_DATA_RESET, rdata: 8'h00,
    txd: 1'b1, rxd_o: 1'b1, rxd_oe: 1'b0, irq: 1'b0, rxd_prev: 1'b1,
    m2_div: 2'h0, t1_pre: 1'b0,
    tx_st: SPU_TX_IDLE, tx_os: 4'h0, tx_bits: 4'h0, tx_sh: 11'h7ff,
    rx_st: SPU_RX_IDLE, rx_os: 4'h0, rx_bits: 4'h0, rx_sh: 9'h000,
    m0_st: SPU_M0_IDLE, m0_cnt: 4'h0, m0_bit: 3'h0, m0_sh: 8'h00
  };

  localparam logic [3:0] OS_LAST  = 4'(`SPU_OS_RATE - 1);
  localparam logic [3:0] OS_MID   = 4'(`SPU_OS_MID - 1);
  localparam logic [3:0] M0_LAST  = 4'(`SPU_M0_DIV - 1);
  localparam logic [3:0] M0_RISE  = 4'(`SPU_M0_HALF);
  localparam logic [1:0] M2_LAST0 = 2'(`SPU_M2_TICK_DIV0 - 1);
  localparam logic [1:0] M2_LAST1 = 2'(`SPU_M2_TICK_DIV1 - 1);
  localparam logic [3:0] FRAME8   = 4'(`SPU_FRAME8_BITS);
  localparam logic [3:0] FRAME9   = 4'(`SPU_FRAME9_BITS);

  logic [1:0]    rst_sync_q;
  logic          rst_n;
  spu_state_t    q;
  spu_state_t    d;
  spu_mode_t     mode;
  logic          uart;
  logic          m2_tick;
  logic          t1_tick;
  logic          tx_tick;
  logic          rx_tick;
  logic          tx_bound;
  logic          rx_sample;
  logic [3:0]    tx_len;
  logic          wr_data;
  logic          buf_valid;
  logic          buf_pop;
  spu_tx_entry_t buf_in;
  spu_tx_entry_t buf_out;
  logic          set_tx_done;
  logic          set_rx_done;
  logic          rx_chk;

  // reset release through two flip-flops
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // mode decode and baud ticks (16 per bit in uart modes)
  assign mode    = spu_mode_t'(q.ctrl[`SPU_BIT_MODE_HI:`SPU_BIT_MODE_LO]);
  assign uart    = (mode != SPU_MODE_SHIFT);
  assign m2_tick = (q.m2_div == (I_BAUD_DOUBLE ? M2_LAST1 : M2_LAST0));
  assign t1_tick = I_TIMER1_OVF & (I_BAUD_DOUBLE | q.t1_pre);
  assign tx_tick = (mode == SPU_MODE_UART9F) ? m2_tick :
                   (I_TX_TIMER_SELECT ? I_TIMER2_OVF : t1_tick);
  assign rx_tick = (mode == SPU_MODE_UART9F) ? m2_tick :
                   (I_RX_TIMER_SELECT ? I_TIMER2_OVF : t1_tick);
  assign tx_bound  = tx_tick & (q.tx_os == OS_LAST);
  assign rx_sample = rx_tick & (q.rx_os == OS_LAST);
  assign tx_len    = (mode == SPU_MODE_UART8) ? FRAME8 : FRAME9;

  // data register writes feed the transmit buffer
  assign wr_data       = I_SFR_WR & (I_SFR_ADDR == `SPU_ADDR_DATA);
  assign buf_in.data   = I_SFR_WDATA;
  assign buf_in.ninth  = q.ctrl[`SPU_BIT_TX_NINTH];
  assign buf_pop       = buf_valid & ((uart & (q.tx_st == SPU_TX_IDLE)) |
                                      (!uart & (q.m0_st == SPU_M0_IDLE)));

  spu_buf2 #(
    .W     ($bits(spu_tx_entry_t)),
    .DEPTH (`SPU_TXBUF_DEPTH)
  ) u_txbuf (
    .i_clk       (I_CLK_SYS),
    .i_rst_n     (rst_n),
    .i_in_valid  (wr_data),
    .o_in_ready  (O_TX_READY),
    .i_in_data   (buf_in),
    .o_out_valid (buf_valid),
    .i_out_ready (buf_pop),
    .o_out_data  (buf_out)
  );

  // next state of the whole port
  always_comb begin
    d           = q;
    set_tx_done = 1'b0;
    set_rx_done = 1'b0;
    rx_chk      = 1'b0;
    d.rxd_prev  = I_RXD;

    // baud prescalers run free
    d.m2_div = m2_tick ? 2'h0 : q.m2_div + 2'h1;
    if (I_TIMER1_OVF) begin
      d.t1_pre = ~q.t1_pre;
    end
    if (tx_tick) begin
      d.tx_os = q.tx_os + 4'h1;
    end

    // uart transmitter
    case (q.tx_st)
      SPU_TX_IDLE: begin
        if (uart && buf_valid) begin
          d.tx_sh = {1'b1, (mode == SPU_MODE_UART8) ? 1'b1 : buf_out.ninth,
                     buf_out.data, 1'b0};
          d.tx_st = SPU_TX_WAIT;
        end
      end
      SPU_TX_WAIT: begin
        if (!uart) begin
          d.tx_st = SPU_TX_IDLE;
        end else if (tx_bound) begin
          d.txd     = q.tx_sh[0];
          d.tx_sh   = {1'b1, q.tx_sh[10:1]};
          d.tx_bits = 4'h1;
          d.tx_st   = SPU_TX_SHIFT;
        end
      end
      SPU_TX_SHIFT: begin
        if (!uart) begin
          d.txd   = 1'b1;
          d.tx_st = SPU_TX_IDLE;
        end else if (tx_bound) begin
          if (q.tx_bits == tx_len) begin
            d.txd   = 1'b1;
            d.tx_st = SPU_TX_IDLE;
          end else begin
            d.txd     = q.tx_sh[0];
            d.tx_sh   = {1'b1, q.tx_sh[10:1]};
            d.tx_bits = q.tx_bits + 4'h1;
            if (q.tx_bits == tx_len - 4'h1) begin
              set_tx_done = 1'b1;
            end
          end
        end
      end
      default: d.tx_st = SPU_TX_IDLE;
    endcase

    // uart receiver
    if (q.rx_st != SPU_RX_IDLE && rx_tick) begin
      d.rx_os = q.rx_os + 4'h1;
    end
    case (q.rx_st)
      SPU_RX_IDLE: begin
        if (uart && q.ctrl[`SPU_BIT_RX_ENABLE] && q.rxd_prev && !I_RXD) begin
          d.rx_os   = 4'h0;
          d.rx_bits = 4'h0;
          d.rx_st   = SPU_RX_START;
        end
      end
      SPU_RX_START: begin
        if (!uart || !q.ctrl[`SPU_BIT_RX_ENABLE]) begin
          d.rx_st = SPU_RX_IDLE;
        end else if (rx_tick && q.rx_os == OS_MID) begin
          d.rx_os = 4'h0;
          d.rx_st = I_RXD ? SPU_RX_IDLE : SPU_RX_DATA;
        end
      end
      SPU_RX_DATA: begin
        if (!uart || !q.ctrl[`SPU_BIT_RX_ENABLE]) begin
          d.rx_st = SPU_RX_IDLE;
        end else if (rx_sample) begin
          d.rx_bits = q.rx_bits + 4'h1;
          if (q.rx_bits < 4'h9) begin
            d.rx_sh = {I_RXD, q.rx_sh[8:1]};
          end
          // last sample: stop bit in 8-bit mode, stop after ninth in 9-bit modes
          if ((mode == SPU_MODE_UART8 && q.rx_bits == 4'h8) ||
              (mode != SPU_MODE_UART8 && q.rx_bits == 4'h9)) begin
            d.rx_st = SPU_RX_IDLE;
            rx_chk  = (mode == SPU_MODE_UART8) ? I_RXD : q.rx_sh[8];
            if (!q.ctrl[`SPU_BIT_RX_DONE] &&
                (!q.ctrl[`SPU_BIT_MULTIPROC] || rx_chk)) begin
              d.rx_data   = (mode == SPU_MODE_UART8) ? q.rx_sh[8:1] : q.rx_sh[7:0];
              set_rx_done = 1'b1;
            end
          end
        end
      end
      default: d.rx_st = SPU_RX_IDLE;
    endcase

    // shift-register mode engine
    if (q.m0_st != SPU_M0_IDLE) begin
      d.m0_cnt = (q.m0_cnt == M0_LAST) ? 4'h0 : q.m0_cnt + 4'h1;
    end
    case (q.m0_st)
      SPU_M0_IDLE: begin
        if (!uart && buf_valid) begin
          d.m0_sh  = buf_out.data;
          d.rxd_o  = buf_out.data[0];
          d.rxd_oe = 1'b1;
          d.txd    = 1'b0;
          d.m0_cnt = 4'h0;
          d.m0_bit = 3'h0;
          d.m0_st  = SPU_M0_TX;
        end else if (!uart && q.ctrl[`SPU_BIT_RX_ENABLE] && !q.ctrl[`SPU_BIT_RX_DONE]) begin
          d.txd    = 1'b0;
          d.m0_cnt = 4'h0;
          d.m0_bit = 3'h0;
          d.m0_st  = SPU_M0_RX;
        end
      end
      SPU_M0_TX, SPU_M0_RX: begin
        if (uart) begin
          d.rxd_oe = 1'b0;
          d.txd    = 1'b1;
          d.m0_st  = SPU_M0_IDLE;
        end else begin
          if (q.m0_cnt == M0_RISE - 4'h1) begin
            d.txd = 1'b1;
          end
          if (q.m0_st == SPU_M0_RX && q.m0_cnt == M0_RISE) begin
            d.m0_sh = {I_RXD, q.m0_sh[7:1]};
          end
          if (q.m0_cnt == M0_LAST) begin
            d.m0_bit = q.m0_bit + 3'h1;
            if (q.m0_bit == 3'h7) begin
              d.rxd_oe = 1'b0;
              d.rxd_o  = 1'b1;
              d.m0_st  = SPU_M0_IDLE;
              if (q.m0_st == SPU_M0_TX) begin
                set_tx_done = 1'b1;
              end else begin
                d.rx_data   = q.m0_sh;
                set_rx_done = 1'b1;
              end
            end else begin
              d.txd = 1'b0;
              if (q.m0_st == SPU_M0_TX) begin
                d.m0_sh = {1'b0, q.m0_sh[7:1]};
                d.rxd_o = q.m0_sh[1];
              end
            end
          end
        end
      end
      default: d.m0_st = SPU_M0_IDLE;
    endcase

    // control register write, hardware sets win over it
    if (I_SFR_WR && I_SFR_ADDR == `SPU_ADDR_CTRL) begin
      d.ctrl = I_SFR_WDATA;
    end
    if (set_tx_done) begin
      d.ctrl[`SPU_BIT_TX_DONE] = 1'b1;
    end
    if (set_rx_done) begin
      d.ctrl[`SPU_BIT_RX_DONE] = 1'b1;
      if (uart) begin
        d.ctrl[`SPU_BIT_RX_NINTH] = rx_chk;
      end
    end

    // register read, answered one cycle later
    if (I_SFR_RD) begin
      if (I_SFR_ADDR == `SPU_ADDR_CTRL) begin
        d.rdata = q.ctrl;
      end else if (I_SFR_ADDR == `SPU_ADDR_DATA) begin
        d.rdata = q.rx_data;
      end else begin
        d.rdata = 8'h00;
      end
    end

    // interrupt request follows both done flags
    d.irq = d.ctrl[`SPU_BIT_TX_DONE] | d.ctrl[`SPU_BIT_RX_DONE];
  end

  // state register
  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      q <= ST_RESET;
    end else begin
      q <= d;
    end
  end

  // outputs straight from state
  assign O_SFR_RDATA  = q.rdata;
  assign O_TXD        = q.txd;
  assign O_RXD        = q.rxd_o;
  assign O_RXD_OE     = q.rxd_oe;
  assign O_SERIAL_IRQ = q.irq;

endmodule : spu_uart
`default_nettype wire

/* File: verif/spu_uart_asserts.sv */
// Purpose: pin and register-read checks of the serial port
// Assumes: one clock domain, mode tracked from control writes
// Notes:   bound to spu_uart below
`timescale 1ns/100ps
`default_nettype none
module spu_uart_asserts (
  // clock, reset and register bus
  input  wire logic               I_CLK_SYS,
  input  wire logic               I_RST_N,
  input  wire spu_pkg::spu_byte_t I_SFR_ADDR,
  input  wire spu_pkg::spu_byte_t I_SFR_WDATA,
  input  wire logic               I_SFR_WR,
  input  wire logic               I_SFR_RD,
  input  wire spu_pkg::spu_byte_t O_SFR_RDATA,
  // baud and pins
  input  wire logic               I_BAUD_DOUBLE,
  input  wire logic               O_RXD_OE,
  input  wire logic               O_TXD,
  input  wire logic               O_SERIAL_IRQ
);
  import spu_pkg::*;
  logic [1:0] mode_q;
  logic [7:0] oe_q;
  logic [9:0] low_q;
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);
  // mode copy, drive-enable length, low run of the transmit pin
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      mode_q <= 2'h0;
      oe_q   <= 8'h00;
      low_q  <= 10'h000;
    end else begin
      if (I_SFR_WR && I_SFR_ADDR == 8'h98) mode_q <= I_SFR_WDATA[7:6];
      oe_q  <= O_RXD_OE ? oe_q + 8'h01 : 8'h00;
      low_q <= O_TXD ? 10'h000 : low_q + 10'h001;
    end
  end
  chk_rd_unmapped: assert property (
    I_SFR_RD && I_SFR_ADDR != 8'h98 && I_SFR_ADDR != 8'h99 |=> O_SFR_RDATA == 8'h00) else $error("unmapped read");
  chk_rdata_hold: assert property (
    !I_SFR_RD |=> $stable(O_SFR_RDATA)) else $error("read data moved without read");
  chk_irq_flags: assert property (
    I_SFR_RD && I_SFR_ADDR == 8'h98 ##1 O_SFR_RDATA[1:0] != 2'b00 |-> ##[0:2] O_SERIAL_IRQ)
    else $error("flag set without request");
  chk_oe_clock: assert property (
    $rose(O_RXD_OE) |-> ##[0:1] !O_TXD) else $error("shift clock not started");
  chk_oe_span: assert property (
    $fell(O_RXD_OE) |-> oe_q == 8'h60) else $error("shift word not 96 clocks");
  chk_sclk_low: assert property (
    $fell(O_TXD) && O_RXD_OE |-> (!O_TXD) [*6] ##1 O_TXD) else $error("shift clock low phase");
  chk_sclk_high: assert property (
    $rose(O_TXD) && O_RXD_OE |-> O_TXD [*6]) else $error("shift clock high phase");
  chk_fixed_bit: assert property (
    $rose(O_TXD) && !O_RXD_OE && mode_q == 2'b10 |->
      low_q[4:0] == 5'h00 && (I_BAUD_DOUBLE || !low_q[5]) && low_q != 10'h000)
    else $error("fixed mode bit length");
endmodule : spu_uart_asserts
bind spu_uart spu_uart_asserts spu_uart_asserts_i (.I_CLK_SYS, .I_RST_N, .I_SFR_ADDR, .I_SFR_WDATA, .I_SFR_WR,
  .I_SFR_RD, .O_SFR_RDATA, .I_BAUD_DOUBLE, .O_RXD_OE, .O_TXD, .O_SERIAL_IRQ);
`default_nettype wire

/* File: verif/spu_peer.sv */
// Purpose: remote station: uart sender and shift-register peripheral
// Assumes: data line pulled high when nobody drives it
// Notes:   frames sent by calling send
`timescale 1ns/100ps
`default_nettype none
module spu_peer (
  // clock and pins
  input  wire logic       i_clk,
  input  wire logic       i_sclk,
  input  wire logic       i_line,
  input  wire logic       i_oe,
  // shift peripheral control
  input  wire logic       i_shift_en,
  input  wire logic [7:0] i_shift_data,
  output logic            o_line,
  output logic [7:0]      o_cap
);
  logic [7:0] sh_q;
  logic       sclk_q;
  logic       en_q;
  initial begin
    o_line = 1'b1;
    o_cap  = 8'h00;
    sclk_q = 1'b1;
    en_q   = 1'b0;
  end
  // next bit on each clock fall, capture device bits on each rise
  always @(negedge i_clk) begin
    sclk_q <= i_sclk;
    en_q   <= i_shift_en;
    if (!i_shift_en) sh_q <= i_shift_data;
    else if (sclk_q && !i_sclk && !i_oe) begin
      o_line <= sh_q[0];
      sh_q   <= {1'b1, sh_q[7:1]};
    end
    if (!sclk_q && i_sclk && i_oe) o_cap <= {i_line, o_cap[7:1]};
    if (en_q && !i_shift_en) o_line <= 1'b1; // released line back to pull-up level
  end
  // one uart frame, start bit first, per clocks a bit
  task automatic send(input logic [10:0] f, input int n, input int per);
    for (int i = 0; i < n; i++) begin
      @(negedge i_clk);
      o_line <= f[i];
      repeat (per - 1) @(negedge i_clk);
    end
    @(negedge i_clk);
    o_line <= 1'b1;
  endtask : send
endmodule : spu_peer
`default_nettype wire

/* File: verif/spu_uart_test.sv */
// Purpose: self-checking bench of the four-mode serial port
// Assumes: doubling on but in one fixed-rate test, first timer every 4 clocks, second every 2
// Notes:   uart bit is 32 or 64 clocks
`timescale 1ns/100ps
`default_nettype none
module spu_uart_test;
  import spu_pkg::*;
  typedef struct packed {
    logic [7:0] ctrl;
    logic       sel;
    logic [7:0] data;
    logic       nin;
    logic       acc;
  } spu_row_t;
  logic      clk, rst_n, wr, rd, sel, t1, t2, shift_en, dbl;
  logic      rdy, rxd_o, oe, txd, irq, peer_line;
  spu_byte_t addr, wdata, rdata, got, last, cap;
  wire logic line;
  int        error_cnt, n_tests, cyc;
  spu_row_t  rows [8] = '{'{8'h78, 1'b0, 8'h3c, 1'b1, 1'b1}, '{8'h70, 1'b1, 8'hc3, 1'b0, 1'b0},
                          '{8'hf0, 1'b0, 8'h5a, 1'b0, 1'b0}, '{8'hf8, 1'b1, 8'ha5, 1'b1, 1'b1},
                          '{8'hb8, 1'b0, 8'h81, 1'b1, 1'b1}, '{8'hd0, 1'b1, 8'h7e, 1'b0, 1'b1},
                          '{8'h48, 1'b0, 8'h11, 1'b1, 1'b0}, '{8'hd9, 1'b1, 8'h22, 1'b1, 1'b0}};
  // data pin seen by both ends
  assign line = oe ? rxd_o : peer_line;
  always #5 clk = ~clk;
  // timer overflow pulses
  always @(negedge clk) begin
    cyc <= cyc + 1;
    t1  <= (cyc % 4) == 0;
    t2  <= (cyc % 2) == 0;
  end
  spu_uart spu_uart_i (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_SFR_ADDR(addr), .I_SFR_WDATA(wdata), .I_SFR_WR(wr),
    .I_SFR_RD(rd), .O_SFR_RDATA(rdata), .O_TX_READY(rdy), .I_BAUD_DOUBLE(dbl), .I_RX_TIMER_SELECT(sel),
    .I_TX_TIMER_SELECT(sel), .I_TIMER1_OVF(t1), .I_TIMER2_OVF(t2), .I_RXD(line), .O_RXD(rxd_o),
    .O_RXD_OE(oe), .O_TXD(txd), .O_SERIAL_IRQ(irq));
  spu_peer spu_peer_i (.i_clk(clk), .i_sclk(txd), .i_line(line), .i_oe(oe), .i_shift_en(shift_en),
    .i_shift_data(8'h5a), .o_line(peer_line), .o_cap(cap));
  // compare and count
  task automatic chk(input string what, input spu_byte_t exp, input spu_byte_t seen);
    n_tests++;
    if (seen !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, seen);
      error_cnt++;
    end
  endtask : chk
  // register write and read strobes
  task automatic wr_reg(input spu_byte_t a, input spu_byte_t d);
    @(negedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(negedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input spu_byte_t a, output spu_byte_t d);
    @(negedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(negedge clk);
    rd <= 1'b0;
    d = rdata;
  endtask : rd_reg
  // sample a uart frame on the transmit pin at mid-bit
  task automatic tx_frame(input logic [10:0] f, input int n, input int per);
    int k;
    for (k = 0; k < 3000 && txd !== 1'b0; k++) @(negedge clk);
    repeat (per / 2) @(negedge clk);
    for (k = 0; k < n; k++) begin
      chk("txd bit", {7'h00, f[k]}, {7'h00, txd});
      repeat (per) @(negedge clk);
    end
  endtask : tx_frame
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  // watchdog
  initial begin
    repeat (60000) @(negedge clk);
    error_cnt++;
    results();
  end
  // main sequence
  initial begin
    spu_row_t   r;
    spu_byte_t  exp;
    logic [10:0] f;
    logic       oe_p;
    int         per, n, k, nfall;
    {clk, rst_n, wr, rd, sel, t1, t2, shift_en, dbl} = 9'h001;
    {addr, wdata} = 16'h0000;
    {error_cnt, n_tests, cyc, nfall} = 128'h0;
    last = 8'h00;
    oe_p = 1'b0;
    repeat (3) @(negedge clk);
    rst_n <= 1'b1;
    repeat (3) @(negedge clk);
    foreach (rows[i]) begin
      r = rows[i];
      sel <= r.sel;
      per = (r.ctrl[7:6] == 2'b10 || r.sel) ? 32 : 64;
      n = r.ctrl[7] ? 11 : 10;
      f = {1'b1, r.ctrl[7] ? r.ctrl[3] : 1'b1, r.data, 1'b0};
      wr_reg(8'h98, r.ctrl);
      wr_reg(8'h99, r.data);
      tx_frame(f, n, per);
      rd_reg(8'h98, got);
      chk("tx flag", r.ctrl | 8'h02, got);
      wr_reg(8'h98, r.ctrl);
      spu_peer_i.send({1'b1, r.nin, r.data, 1'b0}, n, per);
      exp = r.acc ? (r.ctrl | 8'h01 | {5'h00, r.nin, 2'h0}) : r.ctrl;
      rd_reg(8'h98, got);
      chk("rx ctrl", exp, got);
      chk("irq", {7'h00, |exp[1:0]}, {7'h00, irq});
      if (r.acc) last = r.data;
      rd_reg(8'h99, got);
      chk("rx data", last, got);
      $display("row %0d done", i);
    end
    // fixed-rate mode without doubling: 64 clocks a bit
    dbl <= 1'b0;
    wr_reg(8'h98, 8'h80);
    wr_reg(8'h99, 8'h3c);
    tx_frame({2'b10, 8'h3c, 1'b0}, 11, 64);
    dbl <= 1'b1;
    rd_reg(8'h98, got);
    chk("fixed tx flag", 8'h82, got);
    $display("fixed rate test done");
    // shift mode: fill buffer, fourth word refused, three words drained
    wr_reg(8'h98, 8'h00);
    for (int w = 0; w < 4; w++) wr_reg(8'h99, 8'h90 + w[7:0]);
    chk("tx ready full", 8'h00, {7'h00, rdy});
    for (k = 0; k < 600; k++) begin
      @(negedge clk);
      if (oe_p && !oe) nfall++;
      oe_p = oe;
    end
    chk("shift words", 8'h03, nfall[7:0]);
    chk("shift out", 8'h92, cap);
    chk("tx ready", 8'h01, {7'h00, rdy});
    rd_reg(8'h98, got);
    chk("shift tx flag", 8'h02, got);
    $display("shift transmit done");
    // shift mode receive from the peripheral
    shift_en <= 1'b1;
    wr_reg(8'h98, 8'h10);
    for (k = 0; k < 400 && irq !== 1'b1; k++) @(negedge clk);
    shift_en <= 1'b0;
    rd_reg(8'h99, got);
    chk("shift rx data", 8'h5a, got);
    rd_reg(8'h98, got);
    chk("shift rx flag", 8'h11, got);
    $display("shift receive done");
    // second reset, reset values, unmapped access
    rst_n <= 1'b0;
    repeat (3) @(negedge clk);
    rst_n <= 1'b1;
    repeat (3) @(negedge clk);
    chk("idle pins", 8'h09, {4'h0, txd, oe, irq, rdy});
    wr_reg(8'h9a, 8'hff);
    rd_reg(8'h9a, got);
    chk("unmapped", 8'h00, got);
    rd_reg(8'h98, got);
    chk("ctrl reset", 8'h00, got);
    rd_reg(8'h99, got);
    chk("data reset", 8'h00, got);
    $display("reset test done");
    results();
  end
endmodule : spu_uart_test
`default_nettype wire
